// file: src/clk_out_cfg_pkg.sv
// Purpose: constants and carriers for the output clock selection block
// Assumes: 10 MHz mclk, 8-bit register port from the serial front end
// Notes: source taps arrive as plain levels from the pll and synthesis logic
package clk_out_cfg_pkg;
   // register addresses
   localparam logic [7:0] ADDR_FAMILY = 8'h38;
   localparam logic [7:0] ADDR_RATE = 8'h39;
   localparam logic [7:0] ADDR_CAL_LO = 8'h3c;
   localparam logic [7:0] ADDR_CAL_HI = 8'h3d;
   localparam logic [7:0] ADDR_OUT_B = 8'h61;
   localparam logic [7:0] ADDR_OUT_A = 8'h62;
   localparam logic [7:0] ADDR_SYNC_EN = 8'h63;
   localparam logic [7:0] ADDR_SYNC_CTL = 8'h7a;
   // field positions
   localparam int FAM_A_BIT = 5;
   localparam int FAM_B_BIT = 6;
   localparam int RATE_A_LSB = 4;
   localparam int RATE_B_LSB = 6;
   localparam int SEL_B_LSB = 0;
   localparam int SEL_A_LSB = 4;
   localparam int MFS_EN_BIT = 6;
   localparam int FS_EN_BIT = 7;
   localparam int DPLL_SEL_BIT = 7;
   localparam int K8_PULSE_BIT = 3;
   localparam int K8_INV_BIT = 2;
   localparam int K2_PULSE_BIT = 1;
   localparam int K2_INV_BIT = 0;
   // values after reset
   localparam logic [7:0] RST_FAMILY = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h00;
   localparam logic [7:0] RST_OUT_B = 8'h00;
   localparam logic [7:0] RST_OUT_A = 8'h00;
   localparam logic [7:0] RST_SYNC_EN = 8'hc0;
   localparam logic [7:0] RST_SYNC_CTL = 8'h00;
   localparam logic [15:0] RST_CAL = 16'h9999;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int POR_HOLD_MS = 250;
   localparam int POR_HOLD_CYCLES = (POR_HOLD_MS * (CLK_HZ / 1000));
   // selector codes
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_2K = 4'h1;
   localparam logic [3:0] SEL_8K = 4'h2;
   localparam logic [3:0] SEL_SYN_B = 4'h3;
   localparam logic [3:0] SEL_SYN_A = 4'h4;
   localparam logic [3:0] SEL_A48 = 4'h5;
   localparam logic [3:0] SEL_A16 = 4'h6;
   localparam logic [3:0] SEL_A12 = 4'h7;
   localparam logic [3:0] SEL_A8 = 4'h8;
   localparam logic [3:0] SEL_A6 = 4'h9;
   localparam logic [3:0] SEL_A4 = 4'ha;
   localparam logic [3:0] SEL_B64 = 4'hb;
   localparam logic [3:0] SEL_B48 = 4'hc;
   localparam logic [3:0] SEL_B16 = 4'hd;
   localparam logic [3:0] SEL_B8 = 4'he;
   localparam logic [3:0] SEL_B4 = 4'hf;

   // apll_a_tap index: /1 /2 /4 /6 /8 /12 /16 /48
   // apll_b_tap index: /4 /8 /16 /48 /64
   // synth_tap index: {family, rate}; dpll index 0 = pll a, 1 = pll b
   typedef struct packed {
      logic [7:0] apll_a_tap;
      logic [4:0] apll_b_tap;
      logic [7:0] synth_tap;
      logic [1:0] dpll_8k;
      logic [1:0] dpll_2k;
   } source_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic clock_out_a;
      logic clock_out_b;
      logic frame_sync_out;
      logic multiframe_sync_out;
   } outs_t;
endpackage : clk_out_cfg_pkg

// file: src/output_clock_select_config.sv
// Purpose: register file and output muxing for two clock ports and two sync outputs
// Assumes: source levels are asynchronous to mclk; register port is synchronous
// Notes: sources faster than half of mclk alias; real taps need a faster sampler
`timescale 1ns/1ns
`default_nettype none

// Contract
// (R1) clock_out_b selector decodes sixteen codes
// (R2) clock_out_a differs at codes 0011, 0101
// (R3) synth_rate_b has own rate and family
// (R4) synth_rate_a picks one of eight rates
// (R5) sync outputs always from digital_pll_a
// (R6) 2k/8k clock selections pick pll by bit7
// (R7) each 2k/8k output clock or pulse, invertible
// (R8) pulse lasts one clock_out_b period
// (R9) software keeps clock_out_b at least 1544 kHz
// (R10) 8k and 2k pulse/invert controls location
// (R11) sync outputs disabled by bits 7:6
// (R12) power-on reset acts asynchronously
// (R13) reset restores every register default
// (R14) reset state held 250 ms after release
// (R15) calibration word spans two byte locations
// (R16) calibration word resets to 9999 hex
// (R17) master clock comes from 12.8 MHz oscillator; code assumes 10 MHz mclk
// (R18) multi-byte write commits only when uninterrupted
// (R19) hex addresses, eight-bit registers, msb left
// (R20) off selector holds output static
module output_clock_select_config #(
   parameter int HOLD_CYCLES = clk_out_cfg_pkg::POR_HOLD_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic power_on_reset_n,
   // register port
   input wire clk_out_cfg_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // clock sources
   input wire clk_out_cfg_pkg::source_t sources,
   // outputs
   output clk_out_cfg_pkg::outs_t outs,
   output logic [15:0] xo_calibration_word
);
   localparam int SRC_W = $bits(clk_out_cfg_pkg::source_t);
   localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
   // short local aliases of package field positions
   localparam int FAM_A_BIT_ = clk_out_cfg_pkg::FAM_A_BIT;
   localparam int FAM_B_BIT_ = clk_out_cfg_pkg::FAM_B_BIT;
   localparam int RATE_A_LSB_ = clk_out_cfg_pkg::RATE_A_LSB;
   localparam int RATE_B_LSB_ = clk_out_cfg_pkg::RATE_B_LSB;
   localparam int SEL_A_LSB_ = clk_out_cfg_pkg::SEL_A_LSB;
   localparam int SEL_B_LSB_ = clk_out_cfg_pkg::SEL_B_LSB;
   localparam int FS_EN_BIT_ = clk_out_cfg_pkg::FS_EN_BIT;
   localparam int MFS_EN_BIT_ = clk_out_cfg_pkg::MFS_EN_BIT;
   localparam int DPLL_SEL_BIT_ = clk_out_cfg_pkg::DPLL_SEL_BIT;
   localparam int K8_PULSE_BIT_ = clk_out_cfg_pkg::K8_PULSE_BIT;
   localparam int K8_INV_BIT_ = clk_out_cfg_pkg::K8_INV_BIT;
   localparam int K2_PULSE_BIT_ = clk_out_cfg_pkg::K2_PULSE_BIT;
   localparam int K2_INV_BIT_ = clk_out_cfg_pkg::K2_INV_BIT;

   // clock source mux shared by both ports
   function automatic logic pick_source(input logic [3:0] code, input logic port_a,
                                        input clk_out_cfg_pkg::source_t s, input logic syn_a,
                                        input logic syn_b, input logic k2, input logic k8);
      logic v;
      v = 1'b0;
      unique case (code)
         clk_out_cfg_pkg::SEL_OFF: v = 1'b0; // see (R20)
         clk_out_cfg_pkg::SEL_2K: v = k2;
         clk_out_cfg_pkg::SEL_8K: v = k8;
         clk_out_cfg_pkg::SEL_SYN_B: v = port_a ? s.apll_a_tap[1] : syn_b; // see (R1) see (R2)
         clk_out_cfg_pkg::SEL_SYN_A: v = syn_a;
         clk_out_cfg_pkg::SEL_A48: v = port_a ? s.apll_a_tap[0] : s.apll_a_tap[7]; // see (R2)
         clk_out_cfg_pkg::SEL_A16: v = s.apll_a_tap[6];
         clk_out_cfg_pkg::SEL_A12: v = s.apll_a_tap[5];
         clk_out_cfg_pkg::SEL_A8: v = s.apll_a_tap[4];
         clk_out_cfg_pkg::SEL_A6: v = s.apll_a_tap[3];
         clk_out_cfg_pkg::SEL_A4: v = s.apll_a_tap[2];
         clk_out_cfg_pkg::SEL_B64: v = s.apll_b_tap[4];
         clk_out_cfg_pkg::SEL_B48: v = s.apll_b_tap[3];
         clk_out_cfg_pkg::SEL_B16: v = s.apll_b_tap[2];
         clk_out_cfg_pkg::SEL_B8: v = s.apll_b_tap[1];
         clk_out_cfg_pkg::SEL_B4: v = s.apll_b_tap[0];
      endcase
      return v;
   endfunction : pick_source

   // register state
   logic [7:0] family_q, family_d, rate_q, rate_d, out_b_q, out_b_d, out_a_q, out_a_d;
   logic [7:0] sync_en_q, sync_en_d, sync_ctl_q, sync_ctl_d, rdata_q, rdata_d, cal_lo_q, cal_lo_d;
   logic [15:0] cal_q, cal_d;
   logic cal_pend_q, cal_pend_d;
   logic [HOLD_W-1:0] hold_q, hold_d;
   logic run_q, run_d;

   always_comb
   begin
      family_d = family_q;
      rate_d = rate_q;
      out_b_d = out_b_q;
      out_a_d = out_a_q;
      sync_en_d = sync_en_q;
      sync_ctl_d = sync_ctl_q;
      cal_lo_d = cal_lo_q;
      cal_d = cal_q;
      cal_pend_d = cal_pend_q;
      rdata_d = 8'h00;
      hold_d = hold_q;
      run_d = run_q;
      if (!run_q)
      begin
         // writes refused until the hold ends
         if (hold_q == HOLD_W'(HOLD_CYCLES - 1))
            run_d = 1'b1; // see (R14)
         else
            hold_d = hold_q + HOLD_W'(1); // see (R14)
      end
      else if (reg_req.wr || reg_req.rd)
      begin
         // any access other than a low-byte write breaks a pending pair
         cal_pend_d = 1'b0; // see (R18)
         if (reg_req.wr)
         begin
            unique case (reg_req.addr) // see (R19)
               clk_out_cfg_pkg::ADDR_FAMILY: family_d = reg_req.wdata;
               clk_out_cfg_pkg::ADDR_RATE: rate_d = reg_req.wdata;
               clk_out_cfg_pkg::ADDR_OUT_B: out_b_d = reg_req.wdata;
               clk_out_cfg_pkg::ADDR_OUT_A: out_a_d = reg_req.wdata;
               clk_out_cfg_pkg::ADDR_SYNC_EN: sync_en_d = reg_req.wdata;
               clk_out_cfg_pkg::ADDR_SYNC_CTL: sync_ctl_d = reg_req.wdata; // see (R10)
               clk_out_cfg_pkg::ADDR_CAL_LO:
               begin
                  cal_lo_d = reg_req.wdata; // see (R15)
                  cal_pend_d = 1'b1;
               end
               clk_out_cfg_pkg::ADDR_CAL_HI:
               begin
                  if (cal_pend_q)
                     cal_d = {reg_req.wdata, cal_lo_q}; // see (R15) see (R18)
               end
               default: ;
            endcase
         end
         else
         begin
            unique case (reg_req.addr)
               clk_out_cfg_pkg::ADDR_FAMILY: rdata_d = family_q;
               clk_out_cfg_pkg::ADDR_RATE: rdata_d = rate_q;
               clk_out_cfg_pkg::ADDR_OUT_B: rdata_d = out_b_q;
               clk_out_cfg_pkg::ADDR_OUT_A: rdata_d = out_a_q;
               clk_out_cfg_pkg::ADDR_SYNC_EN: rdata_d = sync_en_q;
               clk_out_cfg_pkg::ADDR_SYNC_CTL: rdata_d = sync_ctl_q;
               clk_out_cfg_pkg::ADDR_CAL_LO: rdata_d = cal_q[7:0];
               clk_out_cfg_pkg::ADDR_CAL_HI: rdata_d = cal_q[15:8];
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge power_on_reset_n)
   begin
      if (!power_on_reset_n)
      begin
         // every register back to its default on each reset
         family_q <= clk_out_cfg_pkg::RST_FAMILY; // see (R12) see (R13)
         rate_q <= clk_out_cfg_pkg::RST_RATE;
         out_b_q <= clk_out_cfg_pkg::RST_OUT_B;
         out_a_q <= clk_out_cfg_pkg::RST_OUT_A;
         sync_en_q <= clk_out_cfg_pkg::RST_SYNC_EN;
         sync_ctl_q <= clk_out_cfg_pkg::RST_SYNC_CTL;
         cal_lo_q <= 8'h00;
         cal_q <= clk_out_cfg_pkg::RST_CAL; // see (R16)
         cal_pend_q <= 1'b0;
         rdata_q <= 8'h00;
         hold_q <= '0;
         run_q <= 1'b0;
      end
      else
      begin
         family_q <= family_d;
         rate_q <= rate_d;
         out_b_q <= out_b_d;
         out_a_q <= out_a_d;
         sync_en_q <= sync_en_d;
         sync_ctl_q <= sync_ctl_d;
         cal_lo_q <= cal_lo_d;
         cal_q <= cal_d;
         cal_pend_q <= cal_pend_d;
         rdata_q <= rdata_d;
         hold_q <= hold_d;
         run_q <= run_d;
      end
   end

   // source sampling: three stages, change taken once stages two and three agree
   logic [SRC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   clk_out_cfg_pkg::source_t f;
   assign f = clk_out_cfg_pkg::source_t'(filt_q);

   for (genvar i = 0; i < SRC_W; i++)
   begin : g_filt
      always_comb
      begin
         filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
      end
   end

   always_ff @(posedge mclk or negedge power_on_reset_n)
   begin
      if (!power_on_reset_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end
      else
      begin
         s1_q <= sources;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // rate, pll and timing references
   logic syn_a, syn_b, k8_sel, k2_sel, b_ref, b_ref_prev_q, b_rise;
   assign syn_a = f.synth_tap[{family_q[FAM_A_BIT_], rate_q[RATE_A_LSB_+1 -: 2]}]; // see (R4)
   assign syn_b = f.synth_tap[{family_q[FAM_B_BIT_], rate_q[RATE_B_LSB_+1 -: 2]}]; // see (R3)
   assign k8_sel = f.dpll_8k[sync_ctl_q[DPLL_SEL_BIT_]]; // see (R6)
   assign k2_sel = f.dpll_2k[sync_ctl_q[DPLL_SEL_BIT_]]; // see (R6)
   // pulse timing follows the unshaped clock_out_b source to avoid a loop through itself
   assign b_ref = pick_source(out_b_q[SEL_B_LSB_+3 -: 4], 1'b0, f, syn_a, syn_b, k2_sel, k8_sel);
   assign b_rise = b_ref && !b_ref_prev_q;

   // shapers: 0 frame sync, 1 multiframe sync, 2 port 8k, 3 port 2k
   logic [3:0] lvl, lvl_prev_q, armed_q, armed_d, pulse_q, pulse_d, shaped, pmode, inv;
   assign lvl = {k2_sel, k8_sel, f.dpll_2k[0], f.dpll_8k[0]}; // see (R5)
   assign pmode = {sync_ctl_q[K2_PULSE_BIT_], sync_ctl_q[K8_PULSE_BIT_],
                   sync_ctl_q[K2_PULSE_BIT_], sync_ctl_q[K8_PULSE_BIT_]}; // see (R10)
   assign inv = {sync_ctl_q[K2_INV_BIT_], sync_ctl_q[K8_INV_BIT_],
                 sync_ctl_q[K2_INV_BIT_], sync_ctl_q[K8_INV_BIT_]}; // see (R10)

   for (genvar j = 0; j < 4; j++)
   begin : g_shape
      always_comb
      begin
         armed_d[j] = armed_q[j];
         pulse_d[j] = pulse_q[j];
         // pulse spans rise to rise of clock_out_b, one full period
         if (b_rise)
         begin
            pulse_d[j] = armed_q[j]; // see (R8) see (R9)
            if (armed_q[j])
               armed_d[j] = 1'b0;
         end
         // set after consume: a new 2k/8k rise on a b edge is not lost
         if (lvl[j] && !lvl_prev_q[j])
            armed_d[j] = 1'b1;
         shaped[j] = (pmode[j] ? pulse_q[j] : lvl[j]) ^ inv[j]; // see (R7)
      end
   end

   // output muxing and gating
   clk_out_cfg_pkg::outs_t outs_q, outs_d;
   always_comb
   begin
      outs_d.clock_out_b = pick_source(out_b_q[SEL_B_LSB_+3 -: 4], 1'b0, f, syn_a, syn_b,
                                       shaped[3], shaped[2]); // see (R1)
      outs_d.clock_out_a = pick_source(out_a_q[SEL_A_LSB_+3 -: 4], 1'b1, f, syn_a, syn_b,
                                       shaped[3], shaped[2]); // see (R2)
      outs_d.frame_sync_out = sync_en_q[FS_EN_BIT_] && shaped[0]; // see (R11)
      outs_d.multiframe_sync_out = sync_en_q[MFS_EN_BIT_] && shaped[1]; // see (R11)
      if (!run_q)
         outs_d = '0; // see (R14)
   end

   always_ff @(posedge mclk or negedge power_on_reset_n)
   begin
      if (!power_on_reset_n)
      begin
         b_ref_prev_q <= 1'b0;
         lvl_prev_q <= '0;
         armed_q <= '0;
         pulse_q <= '0;
         outs_q <= '0;
      end
      else
      begin
         b_ref_prev_q <= b_ref;
         lvl_prev_q <= lvl;
         armed_q <= armed_d;
         pulse_q <= pulse_d;
         outs_q <= outs_d;
      end
   end

   // outputs straight from their flip-flops
   assign reg_rdata = rdata_q;
   assign outs = outs_q;
   assign xo_calibration_word = cal_q; // calibration applied in the dpll, see (R17)
endmodule : output_clock_select_config

`default_nettype wire

// file: testbench/output_clock_select_config_properties.sv
// Purpose: port-level checks for the output clock selection block
// Assumes: shadow copies track only writes taken after the hold
// Notes: output checks wait 7 cycles to cover the source filter
`timescale 1ns/1ns
`default_nettype none
module output_clock_select_config_properties #(
   parameter int HOLD_CYCLES = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic power_on_reset_n,
   // register port
   input wire clk_out_cfg_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   // sources and outputs
   input wire clk_out_cfg_pkg::source_t sources,
   input wire clk_out_cfg_pkg::outs_t outs,
   input wire logic [15:0] xo_calibration_word
);
   int hold_cnt;
   logic run;
   logic lo_q;
   logic commit;
   logic [7:0] lo_byte_q;
   logic [7:0] sel_b_q;
   logic [7:0] en_q;
   logic [2:0] boff_q;
   logic [2:0] fsoff_q;
   logic mapped;
   assign run = (hold_cnt == HOLD_CYCLES);
   assign commit = run && reg_req.wr && reg_req.addr == clk_out_cfg_pkg::ADDR_CAL_HI && lo_q;
   assign mapped = reg_req.addr inside {8'h38, 8'h39, 8'h3c, 8'h3d, 8'h61, 8'h62, 8'h63, 8'h7a};
   always_ff @(posedge mclk or negedge power_on_reset_n)
   begin
      if (!power_on_reset_n)
      begin
         hold_cnt <= 0;
         lo_q <= 1'b0;
         lo_byte_q <= 8'h00;
         sel_b_q <= 8'h00;
         en_q <= 8'hc0;
         boff_q <= 3'h0;
         fsoff_q <= 3'h0;
      end
      else
      begin
         if (!run)
            hold_cnt <= hold_cnt + 1;
         if (run && (reg_req.wr || reg_req.rd))
            lo_q <= reg_req.wr && reg_req.addr == clk_out_cfg_pkg::ADDR_CAL_LO;
         if (run && reg_req.wr && reg_req.addr == clk_out_cfg_pkg::ADDR_CAL_LO)
            lo_byte_q <= reg_req.wdata;
         if (run && reg_req.wr && reg_req.addr == 8'h61)
            sel_b_q <= reg_req.wdata;
         if (run && reg_req.wr && reg_req.addr == 8'h63)
            en_q <= reg_req.wdata;
         // saturate so a long off spell keeps the check armed
         boff_q <= (sel_b_q[3:0] != 4'h0) ? 3'h0 : ((boff_q == 3'h7) ? 3'h7 : boff_q + 3'h1);
         fsoff_q <= en_q[7] ? 3'h0 : ((fsoff_q == 3'h7) ? 3'h7 : fsoff_q + 3'h1);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!power_on_reset_n);
   property p_rdata_idle; !$past(reg_req.rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
   property p_unmapped; run && reg_req.rd && !reg_req.wr && !mapped |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_read_b; run && reg_req.rd && !reg_req.wr && reg_req.addr == 8'h61 |=> reg_rdata == sel_b_q; endproperty
   a_read_b: assert property (p_read_b) else $error("selector readback wrong");
   property p_cal_hold; xo_calibration_word != $past(xo_calibration_word) |-> $past(commit); endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("calibration moved without a pair");
   property p_cal_val; commit |-> ##1 xo_calibration_word == {$past(reg_req.wdata), lo_byte_q}; endproperty
   a_cal_val: assert property (p_cal_val) else $error("calibration value wrong");
   property p_hold_outs; !run |-> outs == 4'h0 ##1 reg_rdata == 8'h00; endproperty
   a_hold_outs: assert property (p_hold_outs) else $error("activity during hold");
   property p_rst_cal; $rose(power_on_reset_n) |-> xo_calibration_word == 16'h9999; endproperty
   a_rst_cal: assert property (p_rst_cal) else $error("calibration not at default");
   property p_b_off; boff_q == 3'h7 |-> !outs.clock_out_b; endproperty
   a_b_off: assert property (p_b_off) else $error("off output moving");
   property p_fs_dis; fsoff_q == 3'h7 |-> !outs.frame_sync_out; endproperty
   a_fs_dis: assert property (p_fs_dis) else $error("disabled sync moving");
   c_commit: cover property (commit);
   c_b_off: cover property (boff_q == 3'h7);
   c_read: cover property (run && reg_req.rd);
endmodule : output_clock_select_config_properties
bind output_clock_select_config output_clock_select_config_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
   .mclk(mclk), .power_on_reset_n(power_on_reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .sources(sources), .outs(outs), .xo_calibration_word(xo_calibration_word));
`default_nettype wire

// file: testbench/line_card_model.sv
// Purpose: line card that consumes the four outputs and counts rising edges of clock_out_b and frame_sync_out
// Assumes: clocked by the same master clock as the block
// Notes: a count that moves shows an output that should be static
`timescale 1ns/1ns
`default_nettype none
module line_card_model (
   // sampling clock
   input wire logic mclk,
   // outputs under watch
   input wire clk_out_cfg_pkg::outs_t outs,
   output logic [15:0] n_edge_b,
   output logic [15:0] n_edge_fs
);
   // counters start at zero without a second writer
   clk_out_cfg_pkg::outs_t last = '0;
   logic [15:0] cnt_b = 16'h0000;
   logic [15:0] cnt_fs = 16'h0000;
   assign n_edge_b = cnt_b;
   assign n_edge_fs = cnt_fs;
   always @(posedge mclk)
   begin
      if (outs.clock_out_b && !last.clock_out_b)
         cnt_b <= cnt_b + 16'h0001;
      if (outs.frame_sync_out && !last.frame_sync_out)
         cnt_fs <= cnt_fs + 16'h0001;
      last <= outs;
   end
endmodule : line_card_model
`default_nettype wire

// file: testbench/test_output_clock_select_config.sv
// Purpose: self-checking bench for output clock selection and registers
// Assumes: hold shortened to 16 cycles
// Notes: sources held static while chk_out compares outputs; edge-count and pulse checks move them every cycle
`timescale 1ns/1ns
`default_nettype none
module test_output_clock_select_config;
   localparam int HOLD = 16;
   logic mclk;
   logic power_on_reset_n;
   clk_out_cfg_pkg::reg_req_t req;
   logic [7:0] reg_rdata;
   clk_out_cfg_pkg::source_t src;
   clk_out_cfg_pkg::outs_t outs;
   logic [15:0] cal;
   logic [15:0] eb;
   logic [15:0] efs;
   int n_mismatch;
   int comparisons;
   logic [7:0] mdl [logic [7:0]];
   logic [15:0] mcal;
   logic [7:0] pend;
   bit armed;
   logic [7:0] addrs [9] = '{8'h38, 8'h39, 8'h3c, 8'h3d, 8'h61, 8'h62, 8'h63, 8'h7a, 8'h40};
   output_clock_select_config #(.HOLD_CYCLES(HOLD)) dut (.mclk(mclk), .power_on_reset_n(power_on_reset_n),
      .reg_req(req), .reg_rdata(reg_rdata), .sources(src), .outs(outs), .xo_calibration_word(cal));
   line_card_model card (.mclk(mclk), .outs(outs), .n_edge_b(eb), .n_edge_fs(efs));
   always #50 mclk = ~mclk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic mreset;
      mdl = '{8'h38: 8'h00, 8'h39: 8'h00, 8'h61: 8'h00, 8'h62: 8'h00, 8'h63: 8'hc0, 8'h7a: 8'h00};
      mcal = 16'h9999;
      armed = 0;
   endtask : mreset
   function automatic logic [7:0] mread(input logic [7:0] a);
      if (a == clk_out_cfg_pkg::ADDR_CAL_LO)
         return mcal[7:0];
      if (a == clk_out_cfg_pkg::ADDR_CAL_HI)
         return mcal[15:8];
      return mdl.exists(a) ? mdl[a] : 8'h00;
   endfunction : mread
   // one access per edge; caller ends a burst with idle
   task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
      req.wr = w;
      req.rd = !w;
      req.addr = a;
      req.wdata = d;
      @(posedge mclk);
      #1;
      if (!w)
         check(reg_rdata, mread(a));
      else if (a == clk_out_cfg_pkg::ADDR_CAL_HI && armed)
         mcal = {d, pend};
      else if (mdl.exists(a))
         mdl[a] = d;
      pend = d;
      armed = w && a == clk_out_cfg_pkg::ADDR_CAL_LO;
   endtask : acc
   task automatic idle;
      req = '0;
      @(posedge mclk);
      #1;
   endtask : idle
   function automatic logic tap(input logic [3:0] c, input bit a);
      logic [7:0] ctl;
      ctl = mdl[8'h7a];
      case (c)
         4'h0: return 1'b0;
         4'h1: return src.dpll_2k[ctl[7]] ^ ctl[0];
         4'h2: return src.dpll_8k[ctl[7]] ^ ctl[2];
         4'h3: return a ? src.apll_a_tap[1] : src.synth_tap[{mdl[8'h38][6], mdl[8'h39][7:6]}];
         4'h4: return src.synth_tap[{mdl[8'h38][5], mdl[8'h39][5:4]}];
         4'h5: return a ? src.apll_a_tap[0] : src.apll_a_tap[7];
         4'hb, 4'hc, 4'hd, 4'he, 4'hf: return src.apll_b_tap[15 - c];
         default: return src.apll_a_tap[12 - c];
      endcase
   endfunction : tap
   task automatic chk_out;
      logic [7:0] ctl;
      logic [7:0] en;
      repeat (8) @(posedge mclk);
      #1;
      ctl = mdl[8'h7a];
      en = mdl[8'h63];
      check(outs.clock_out_b, tap(mdl[8'h61][3:0], 0));
      check(outs.clock_out_a, tap(mdl[8'h62][7:4], 1));
      check(outs.frame_sync_out, en[7] & (src.dpll_8k[0] ^ ctl[2]));
      check(outs.multiframe_sync_out, en[6] & (src.dpll_2k[0] ^ ctl[0]));
   endtask : chk_out
   task automatic rd_all;
      foreach (addrs[i])
         acc(0, addrs[i], 8'h00);
      acc(1, 8'h41, 8'h5a);
      acc(0, 8'h41, 8'h00);
      idle();
   endtask : rd_all
   initial
   begin
      #5_000_000;
      n_mismatch++;
      print_verdict();
   end
   initial
   begin
      logic [15:0] e0;
      logic [15:0] f0;
      logic [15:0] hi_fs;
      logic [15:0] hi_mfs;
      mclk = 0;
      power_on_reset_n = 0;
      req = '0;
      src = '0;
      n_mismatch = 0;
      comparisons = 0;
      void'($urandom(48));
      mreset();
      repeat (5) @(posedge mclk);
      #1;
      power_on_reset_n = 1;
      // write held through the whole hold must be ignored
      req.wr = 1;
      req.addr = 8'h61;
      req.wdata = 8'hff;
      repeat (HOLD) @(posedge mclk);
      #1;
      rd_all();
      acc(1, clk_out_cfg_pkg::ADDR_CAL_LO, 8'h9a);
      acc(1, clk_out_cfg_pkg::ADDR_CAL_HI, 8'h98);
      idle();
      check(cal, mcal);
      acc(1, clk_out_cfg_pkg::ADDR_CAL_LO, 8'h11);
      acc(0, 8'h61, 8'h00);
      acc(1, clk_out_cfg_pkg::ADDR_CAL_HI, 8'h22);
      acc(1, clk_out_cfg_pkg::ADDR_CAL_HI, 8'h33);
      idle();
      check(cal, mcal);
      // pulse bits stay clear, so the clock_out_b floor never applies
      for (int c = 0; c < 16; c++)
      begin
         acc(1, 8'h61, {4'h0, c[3:0]});
         acc(1, 8'h62, {c[3:0], 4'h0});
         acc(1, 8'h38, 8'($urandom));
         acc(1, 8'h39, 8'($urandom));
         acc(1, 8'h7a, 8'($urandom) & 8'h85);
         acc(1, 8'h63, 8'($urandom) & 8'hc0);
         idle();
         repeat (2)
         begin
            src = 25'($urandom);
            chk_out();
         end
      end
      rd_all();
      acc(1, 8'h61, 8'h00);
      acc(1, 8'h63, 8'h00);
      idle();
      repeat (8) idle();
      e0 = eb;
      f0 = efs;
      repeat (30)
      begin
         src = 25'($urandom);
         idle();
      end
      check(eb, e0);
      check(efs, f0);
      // pulse mode: clock_out_b at 2.5 MHz keeps above its floor
      acc(1, 8'h61, 8'h0f);
      acc(1, 8'h63, 8'hc0);
      acc(1, 8'h7a, 8'h0a);
      idle();
      hi_fs = 16'h0000;
      hi_mfs = 16'h0000;
      for (int i = 0; i < 48; i++)
      begin
         src = '0;
         src.apll_b_tap[0] = (i % 4) < 2;
         src.dpll_8k[0] = i >= 24;
         src.dpll_2k[0] = i >= 24;
         idle();
         // early cycles drain pulses left from the random phase
         if (i >= 16)
         begin
            hi_fs = hi_fs + 16'(outs.frame_sync_out);
            hi_mfs = hi_mfs + 16'(outs.multiframe_sync_out);
         end
      end
      check(hi_fs, 16'h0004);
      check(hi_mfs, 16'h0004);
      // reset between edges must act at once
      power_on_reset_n = 0;
      #10;
      check(outs, 4'h0);
      check(cal, 16'h9999);
      @(posedge mclk);
      #1;
      power_on_reset_n = 1;
      mreset();
      repeat (HOLD) @(posedge mclk);
      #1;
      rd_all();
      print_verdict();
   end
endmodule : test_output_clock_select_config
`default_nettype wire
